// ---- hdl/eifx_frame_counter.sv ----
// microframe timer and 14-bit frame index counter with list wrap detection
`timescale 1ns/100ps
module eifx_frame_counter import eifx_pkg::*; #(
  parameter int unsigned TICK_CYCLES = EIFX_MICROFRAME_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic count_en_i,
  input wire logic load_i,
  input wire logic [13:0] load_value_i,
  input wire logic [1:0] len_code_i,
  output logic [13:0] index_o,
  output logic tick_o,
  output logic wrap_o
);

  logic [15:0] timer;
  wire timer_end = count_en_i && (timer == 16'(TICK_CYCLES - 1));
  wire [13:0] index_inc = index_o + 14'h0001;
  // the list rolls over when every index bit from N down drops to zero
  wire index_wraps = (index_inc & eifx_index_mask(len_code_i)) == 14'h0000;

  // timer restarts whenever the controller is halted so a run starts on a full microframe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !count_en_i || timer_end) begin
      timer <= 16'h0000;
    end else begin
      timer <= timer + 16'h0001;
    end
  end

  // index advances once per microframe; loads come only while halted
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      index_o <= EIFX_FRAME_IDX_RESET;
      tick_o <= 1'b0;
      wrap_o <= 1'b0;
    end else begin
      tick_o <= timer_end;
      wrap_o <= timer_end && index_wraps;
      if (load_i) begin
        index_o <= load_value_i;
      end else if (timer_end) begin
        index_o <= index_inc;
      end
    end
  end

endmodule

// ---- hdl/eifx_irq_gate.sv ----
// gates status bits through enables onto one host interrupt, with threshold hold-off
`timescale 1ns/100ps
module eifx_irq_gate import eifx_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] status_i,
  input wire logic [5:0] enable_i,
  input wire logic boundary_i,
  output logic irq_o
);

  logic pending;
  wire [5:0] active = status_i & enable_i;
  wire imm_any = |(active & EIFX_IMMEDIATE_MASK);
  wire thr_any = |(active & EIFX_THRESH_MASK);
  // threshold sources arm only on a boundary and release when acknowledged
  wire next_pending = thr_any && (pending || boundary_i);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pending <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      pending <= next_pending;
      irq_o <= imm_any || next_pending;
    end
  end

endmodule

// ---- hdl/eifx_pkg.sv ----
// package: offsets, fields, reset values and timing for the irq-enable / frame-index slice
package eifx_pkg;

  // register offsets in the operational space
  localparam logic [7:0] EIFX_OFS_COMMAND = 8'h0C;
  localparam logic [7:0] EIFX_OFS_STATUS = 8'h10;
  localparam logic [7:0] EIFX_OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] EIFX_OFS_FRAME_IDX = 8'h18;
  localparam logic [7:0] EIFX_OFS_SEGMENT = 8'h1C;
  localparam logic [7:0] EIFX_OFS_LIST_START = 8'h20;

  // field positions
  localparam int EIFX_CMD_RUN_BIT = 0;
  localparam int EIFX_CMD_LEN_LSB = 2;
  localparam int EIFX_STS_HALT_BIT = 12;
  localparam int EIFX_SRC_DONE = 0;
  localparam int EIFX_SRC_ERROR = 1;
  localparam int EIFX_SRC_PORT = 2;
  localparam int EIFX_SRC_WRAP = 3;
  localparam int EIFX_SRC_FAULT = 4;
  localparam int EIFX_SRC_ASYNC = 5;
  localparam int EIFX_LIST_BASE_LSB = 12;

  // sources held to the threshold boundary versus sources raised at once
  localparam logic [5:0] EIFX_THRESH_MASK = 6'h23;
  localparam logic [5:0] EIFX_IMMEDIATE_MASK = 6'h1C;

  // reset values
  localparam logic [5:0] EIFX_IRQ_EN_RESET = 6'h00;
  localparam logic [13:0] EIFX_FRAME_IDX_RESET = 14'h0000;
  localparam logic [19:0] EIFX_LIST_START_RESET = 20'h00000;
  localparam logic [31:0] EIFX_SEGMENT_RESET = 32'h00000000;

  // microframe timing at the 40 MHz system clock
  localparam int EIFX_MICROFRAME_NS = 125000;
  localparam int EIFX_CLK_PERIOD_NS = 25;
  localparam int EIFX_MICROFRAME_CYCLES = EIFX_MICROFRAME_NS / EIFX_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    EIFX_LEN_1024 = 2'b00,
    EIFX_LEN_512 = 2'b01,
    EIFX_LEN_256 = 2'b10,
    EIFX_LEN_RSVD = 2'b11
  } eifx_len_t;

  typedef enum logic [1:0] {
    EIFX_ST_HALTED = 2'b00,
    EIFX_ST_RUNNING = 2'b01,
    EIFX_ST_STOPPING = 2'b10
  } eifx_run_t;

  // counter bits N..0 that take part in the list index; reserved code acts as 1024
  function automatic logic [13:0] eifx_index_mask(input logic [1:0] len);
    case (len)
      EIFX_LEN_512: eifx_index_mask = 14'h0FFF;
      EIFX_LEN_256: eifx_index_mask = 14'h07FF;
      default: eifx_index_mask = 14'h1FFF;
    endcase
  endfunction

endpackage

// ---- hdl/eifx_regs.sv ----
// operational register slice: interrupt enable, frame index, segment and periodic list start
`timescale 1ns/100ps
module eifx_regs import eifx_pkg::*; #(
  parameter int unsigned MICROFRAME_CYCLES = EIFX_MICROFRAME_CYCLES,
  parameter bit WIDE_ADDR = 1'b1,
  parameter bit PROG_LIST_LEN = 1'b1
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [3:0] REG_BE_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic [5:0] STATUS_EVENT_I,
  output logic [31:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  output logic HOST_IRQ_O,
  output logic HALTED_O,
  output logic MICROFRAME_TICK_O,
  output logic [10:0] SOF_FRAME_O,
  output logic [63:0] LIST_ENTRY_ADDR_O
);

  logic run_stop_control;
  logic [1:0] list_length_code;
  logic [5:0] status_bits;
  logic [5:0] irq_enable;
  logic [31:0] upper_address_segment;
  logic [19:0] periodic_list_start;
  logic halted_status;
  eifx_run_t run_state;
  eifx_run_t next_run_state;
  logic [13:0] frame_index;
  logic tick;
  logic wrap;
  logic [15:0] stop_cycles;

  // byte-lane merge shared by the command, enable, segment and list start writes; a lane left out keeps its old bits
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word, input logic [31:0] new_word,
                                              input logic [31:0] mask);
    merge_bytes = (old_word & ~mask) | (new_word & mask);
  endfunction

  // address decode
  wire hit_cmd = REG_ADDR_I == EIFX_OFS_COMMAND;
  wire hit_sts = REG_ADDR_I == EIFX_OFS_STATUS;
  wire hit_ien = REG_ADDR_I == EIFX_OFS_IRQ_EN;
  wire hit_fidx = REG_ADDR_I == EIFX_OFS_FRAME_IDX;
  wire hit_seg = REG_ADDR_I == EIFX_OFS_SEGMENT;
  wire hit_base = REG_ADDR_I == EIFX_OFS_LIST_START;

  // write data merged under byte enables, per register
  wire [31:0] be_mask = {{8{REG_BE_I[3]}}, {8{REG_BE_I[2]}}, {8{REG_BE_I[1]}}, {8{REG_BE_I[0]}}};
  wire [31:0] cmd_word = {28'h0000000, list_length_code, 1'b0, run_stop_control};
  wire [31:0] sts_word = {19'h00000, halted_status, 6'h00, status_bits};
  wire [31:0] ien_word = {26'h0000000, irq_enable};
  wire [31:0] fidx_word = {18'h00000, frame_index};
  wire [31:0] seg_word = WIDE_ADDR ? upper_address_segment : 32'h00000000;
  wire [31:0] base_word = {periodic_list_start, 12'h000};
  wire [31:0] cmd_new = merge_bytes(cmd_word, REG_WDATA_I, be_mask);
  wire [31:0] ien_new = merge_bytes(ien_word, REG_WDATA_I, be_mask);
  wire [31:0] seg_new = merge_bytes(upper_address_segment, REG_WDATA_I, be_mask);
  wire [31:0] base_new = merge_bytes(base_word, REG_WDATA_I, be_mask);

  // write strobes; frame index takes only a whole-word write while halted
  wire wr_cmd = REG_WR_I && hit_cmd;
  wire wr_ien = REG_WR_I && hit_ien;
  wire wr_seg = REG_WR_I && hit_seg && WIDE_ADDR;
  wire wr_base = REG_WR_I && hit_base;
  wire fidx_load = REG_WR_I && hit_fidx && halted_status && (REG_BE_I == 4'hF);

  // status events: external sources plus the counter's own rollover
  wire [5:0] ev_set = STATUS_EVENT_I | {2'b00, wrap, 3'b000};
  wire [5:0] w1c = (REG_WR_I && hit_sts) ? (REG_WDATA_I[5:0] & be_mask[5:0]) : 6'h00;
  wire fault_evt = STATUS_EVENT_I[EIFX_SRC_FAULT];

  // read mux; unmapped offsets read zero
  wire [31:0] rd_word = hit_cmd ? cmd_word :
                        hit_sts ? sts_word :
                        hit_ien ? ien_word :
                        hit_fidx ? fidx_word :
                        hit_seg ? seg_word :
                        hit_base ? base_word : 32'h00000000;

  // periodic list entry address: segment, base, index bits N..3, dword aligned
  wire [13:0] masked_index = frame_index & eifx_index_mask(list_length_code);
  wire [63:0] entry_addr = {seg_word, periodic_list_start, masked_index[12:3], 2'b00};

  // command bits; a host fault drops run so no further schedule work is done
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      run_stop_control <= 1'b0;
      list_length_code <= EIFX_LEN_1024;
    end else begin
      if (fault_evt) begin
        run_stop_control <= 1'b0;
      end else if (wr_cmd) begin
        run_stop_control <= cmd_new[EIFX_CMD_RUN_BIT];
      end
      if (wr_cmd && PROG_LIST_LEN) begin
        list_length_code <= cmd_new[EIFX_CMD_LEN_LSB +: 2];
      end
    end
  end

  // sticky status: a set in the same cycle as its clear wins
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      status_bits <= 6'h00;
    end else begin
      status_bits <= ev_set | (status_bits & ~w1c);
    end
  end

  // writable configuration registers
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      irq_enable <= EIFX_IRQ_EN_RESET;
      upper_address_segment <= EIFX_SEGMENT_RESET;
      periodic_list_start <= EIFX_LIST_START_RESET;
    end else begin
      if (wr_ien) begin
        irq_enable <= ien_new[5:0];
      end
      if (wr_seg) begin
        upper_address_segment <= seg_new;
      end
      if (wr_base) begin
        periodic_list_start <= base_new[31:EIFX_LIST_BASE_LSB];
      end
    end
  end

  // run/stop sequencing: stopping finishes the current microframe before halting
  always_comb begin
    next_run_state = run_state;
    case (run_state)
      EIFX_ST_HALTED: begin
        if (run_stop_control) begin
          next_run_state = EIFX_ST_RUNNING;
        end
      end
      EIFX_ST_RUNNING: begin
        if (!run_stop_control) begin
          next_run_state = EIFX_ST_STOPPING;
        end
      end
      EIFX_ST_STOPPING: begin
        if (run_stop_control) begin
          next_run_state = EIFX_ST_RUNNING;
        end else if (tick) begin
          next_run_state = EIFX_ST_HALTED;
        end
      end
      default: next_run_state = EIFX_ST_HALTED;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      run_state <= EIFX_ST_HALTED;
      halted_status <= 1'b1;
    end else begin
      run_state <= next_run_state;
      halted_status <= next_run_state == EIFX_ST_HALTED;
    end
  end

  eifx_frame_counter #(
    .TICK_CYCLES(MICROFRAME_CYCLES)
  ) u_counter (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESET_N_I),
    .count_en_i(run_state != EIFX_ST_HALTED),
    .load_i(fidx_load),
    .load_value_i(REG_WDATA_I[13:0]),
    .len_code_i(list_length_code),
    .index_o(frame_index),
    .tick_o(tick),
    .wrap_o(wrap)
  );

  // the microframe boundary doubles as the interrupt threshold
  eifx_irq_gate u_irq (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESET_N_I),
    .status_i(status_bits),
    .enable_i(irq_enable),
    .boundary_i(tick),
    .irq_o(HOST_IRQ_O)
  );

  // registered outputs; SOF and entry address lag the index by one cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= 32'h00000000;
      REG_RVALID_O <= 1'b0;
      SOF_FRAME_O <= 11'h000;
      LIST_ENTRY_ADDR_O <= 64'h0000000000000000;
      MICROFRAME_TICK_O <= 1'b0;
      HALTED_O <= 1'b1;
    end else begin
      REG_RDATA_O <= REG_RD_I ? rd_word : 32'h00000000;
      REG_RVALID_O <= REG_RD_I;
      SOF_FRAME_O <= frame_index[13:3];
      LIST_ENTRY_ADDR_O <= entry_addr;
      MICROFRAME_TICK_O <= tick;
      HALTED_O <= next_run_state == EIFX_ST_HALTED;
    end
  end

  // checks on the slice's own behaviour
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);

  wire [5:0] ev_unmasked = ev_set & ~irq_enable;

  a_irq_needs_enable: assert property (HOST_IRQ_O |-> $past(|(status_bits & irq_enable)))
    else $error("interrupt raised with no enabled status bit");
  a_status_polled: assert property ((ev_unmasked != 6'h00) |=> ((status_bits & $past(ev_unmasked)) == $past(ev_unmasked)))
    else $error("disabled source failed to set its status bit");
  a_async_waits: assert property ((!HOST_IRQ_O && !tick && ((status_bits & irq_enable) == 6'h20)) |=> !HOST_IRQ_O)
    else $error("async advance interrupt did not wait for threshold");
  a_fault_at_once: assert property ((status_bits[EIFX_SRC_FAULT] && irq_enable[EIFX_SRC_FAULT]) |=> HOST_IRQ_O)
    else $error("host fault interrupt not raised at once");
  a_wrap_at_once: assert property ((status_bits[EIFX_SRC_WRAP] && irq_enable[EIFX_SRC_WRAP]) |=> HOST_IRQ_O)
    else $error("list wrap interrupt not raised at once");
  a_port_at_once: assert property ((status_bits[EIFX_SRC_PORT] && irq_enable[EIFX_SRC_PORT]) |=> HOST_IRQ_O)
    else $error("port change interrupt not raised at once");
  a_threshold_fire: assert property ((tick && |(status_bits & irq_enable & 6'h03)) |=> HOST_IRQ_O)
    else $error("transfer interrupt missing at threshold boundary");
  a_irq_drops: assert property (((status_bits & irq_enable) == 6'h00) |=> !HOST_IRQ_O)
    else $error("interrupt held with no enabled status bit");
  a_enable_reserved: assert property ((REG_RD_I && hit_ien) |=> (REG_RVALID_O && REG_RDATA_O[31:6] == 26'h0000000))
    else $error("interrupt enable reserved bits read nonzero");
  a_index_steps: assert property (($changed(frame_index) && !$past(fidx_load)) |-> (tick && frame_index == $past(frame_index) + 14'h0001))
    else $error("frame index moved off the microframe boundary");
  a_sof_number: assert property (##1 SOF_FRAME_O == $past(frame_index[13:3]))
    else $error("SOF frame number does not follow frame index");
  a_write_halted: assert property (($changed(frame_index) && !tick) |-> $past(halted_status))
    else $error("frame index changed by write while running");
  a_segment_zero: assert property (!WIDE_ADDR |-> LIST_ENTRY_ADDR_O[63:32] == 32'h00000000)
    else $error("segment used without wide addressing");
  a_run_clears_halt: assert property (run_stop_control |=> !halted_status)
    else $error("halted status set while run is on");
  a_wrap_sets_status: assert property (wrap |=> status_bits[EIFX_SRC_WRAP])
    else $error("list rollover did not set wrap status");

  // cycles spent stopping; a stop must end within one microframe, so a hung
  // stop shows up here rather than as a silent halted bit that never comes
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I || run_state != EIFX_ST_STOPPING) begin
      stop_cycles <= 16'h0000;
    end else begin
      stop_cycles <= stop_cycles + 16'h0001;
    end
  end

  // stopping and run control
  a_stop_bounded: assert property (stop_cycles <= 16'(MICROFRAME_CYCLES))
    else $error("stop did not reach halted within one microframe");
  a_fault_stops_run: assert property (fault_evt |=> !run_stop_control)
    else $error("host fault left run control set");

  // frame index loads, refusals and list rollover
  a_index_load: assert property (fidx_load |=> frame_index == $past(REG_WDATA_I[13:0]))
    else $error("frame index load did not take the written value");
  a_byte_refused: assert property ((REG_WR_I && hit_fidx && REG_BE_I != 4'hF) |=> (frame_index == $past(frame_index)) || tick)
    else $error("partial write changed the frame index");
  a_wrap_rollover: assert property (wrap |-> (tick && (frame_index & eifx_index_mask(list_length_code)) == 14'h0000))
    else $error("wrap flagged away from a list rollover");

  // list entry address pieces, one cycle behind their sources
  a_list_index: assert property (LIST_ENTRY_ADDR_O[11:2] == $past(masked_index[12:3]))
    else $error("entry address index bits wrong");
  a_entry_base: assert property (LIST_ENTRY_ADDR_O[31:12] == $past(periodic_list_start))
    else $error("entry address base bits wrong");
  a_entry_segment: assert property (WIDE_ADDR |-> LIST_ENTRY_ADDR_O[63:32] == $past(upper_address_segment))
    else $error("entry address segment bits wrong");
  a_entry_aligned: assert property (LIST_ENTRY_ADDR_O[1:0] == 2'b00)
    else $error("entry address not dword aligned");

  // register writes and reserved fields
  a_enable_write: assert property (wr_ien |=> irq_enable == $past(ien_new[5:0]))
    else $error("interrupt enable write lost");
  a_segment_write: assert property (wr_seg |=> upper_address_segment == $past(seg_new))
    else $error("segment write lost");
  a_base_write: assert property (wr_base |=> periodic_list_start == $past(base_new[31:12]))
    else $error("list start write lost");
  a_length_write: assert property ((wr_cmd && PROG_LIST_LEN) |=> list_length_code == $past(cmd_new[3:2]))
    else $error("list length code write lost");
  a_status_clear: assert property ((REG_WR_I && hit_sts && REG_BE_I[0] && STATUS_EVENT_I == 6'h00 && !wrap)
                                   |=> (status_bits & $past(REG_WDATA_I[5:0])) == 6'h00)
    else $error("status bit survived its clear");
  a_status_reserved: assert property ((REG_RD_I && hit_sts) |=> (REG_RDATA_O[31:13] == 19'h00000 && REG_RDATA_O[11:6] == 6'h00))
    else $error("status reserved bits read nonzero");
  a_base_reserved: assert property ((REG_RD_I && hit_base) |=> REG_RDATA_O[11:0] == 12'h000)
    else $error("list start reserved bits read nonzero");
  a_index_reserved: assert property ((REG_RD_I && hit_fidx) |=> REG_RDATA_O[31:14] == 18'h00000)
    else $error("frame index reserved bits read nonzero");

  c_irq_raised: cover property (!HOST_IRQ_O ##1 HOST_IRQ_O);
  c_byte_refused: cover property (REG_WR_I && hit_fidx && REG_BE_I != 4'hF);
  c_list_wrap: cover property (wrap);
  c_stop_done: cover property (run_state == EIFX_ST_STOPPING ##1 run_state == EIFX_ST_HALTED);
  c_threshold_irq: cover property (tick && |(status_bits & irq_enable & 6'h03));

endmodule

// ---- sim/tb_eifx_regs.sv ----
// self-checking bench for the irq-enable / frame-index register slice
`timescale 1ns/100ps
module tb_eifx_regs import eifx_pkg::*;;
  localparam int M = 8; // short microframe keeps the run brief
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'h0;
  logic [31:0] wdata = 32'h00000000;
  logic [5:0] ev = 6'h00;
  logic [31:0] rdata, seg, base, r, q;
  logic rvalid, irq, halted, tick;
  logic [10:0] sof;
  logic [63:0] ent;
  logic [13:0] idx, top;
  int failures = 0, total_checks = 0, cyc = 0, n;
  logic [7:0] ra[7] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h40};
  logic [31:0] rv[7] = '{32'h00000000, 32'h00001000, 32'h00000000, 32'h00000000, 32'h00000000,
                         32'h00000000, 32'h00000000};
  int thr[3] = '{0, 1, 5};

  eifx_regs #(.MICROFRAME_CYCLES(M), .WIDE_ADDR(1'b1), .PROG_LIST_LEN(1'b1)) dut_u (
    .CLK_SYS_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_BE_I(be), .REG_WDATA_I(wdata), .STATUS_EVENT_I(ev), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .HOST_IRQ_O(irq), .HALTED_O(halted), .MICROFRAME_TICK_O(tick),
    .SOF_FRAME_O(sof), .LIST_ENTRY_ADDR_O(ent));

  // 40 MHz system clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  // hang guard, generous against the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // sample point one step after the edge so the edge's updates have landed
  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    be <= b;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read valid", rvalid, 1'b1);
    d = rdata;
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    ev <= 6'h01 << b;
    @(posedge clk);
    ev <= 6'h00;
  endtask

  task automatic wait_tick(output int k);
    k = 0;
    while (tick !== 1'b1 && k < 3 * M) begin
      cyc_n(1);
      k++;
    end
    chk("tick", tick, 1'b1);
  endtask

  task automatic wait_halt;
    int k;
    k = 0;
    while (halted !== 1'b1 && k < 3 * M) begin
      cyc_n(1);
      k++;
    end
    chk("halted", halted, 1'b1);
  endtask

  // list entry address worked out from base, segment and the length code
  function automatic logic [63:0] ent_exp(input logic [1:0] c, input logic [13:0] i);
    logic [9:0] f;
    f = (c == 2'b01) ? {1'b0, i[11:3]} : (c == 2'b10) ? {2'b00, i[10:3]} : i[12:3];
    return {seg, base[31:12], f, 2'b00};
  endfunction

  initial begin
    r = $urandom(91611);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    cyc_n(1);
    chk("halted", halted, 1'b1);
    chk("irq", irq, 1'b0);
    for (int k = 0; k < 7; k++) begin
      rd_reg(ra[k], q);
      chk("reset value", q, rv[k]);
    end
    // random register traffic, all while halted
    for (int k = 0; k < 8; k++) begin
      seg = $urandom;
      base = $urandom;
      r = $urandom;
      idx = r[13:0];
      wr_reg(EIFX_OFS_IRQ_EN, ~r, 4'hF);
      rd_reg(EIFX_OFS_IRQ_EN, q);
      chk("enable", q, ~r & 32'h0000003F);
      wr_reg(EIFX_OFS_SEGMENT, seg, 4'hF);
      rd_reg(EIFX_OFS_SEGMENT, q);
      chk("segment", q, seg);
      wr_reg(EIFX_OFS_LIST_START, base, 4'hF);
      rd_reg(EIFX_OFS_LIST_START, q);
      chk("list start", q, base & 32'hFFFFF000);
      wr_reg(EIFX_OFS_FRAME_IDX, r, 4'hF);
      wr_reg(EIFX_OFS_FRAME_IDX, ~r, 4'h1);
      rd_reg(EIFX_OFS_FRAME_IDX, q);
      chk("frame index", q, {18'h00000, idx});
      chk("sof", sof, idx[13:3]);
      chk("entry", ent, ent_exp(2'b00, idx));
      wr_reg(8'h44, r, 4'hF);
      rd_reg(8'h44, q);
      chk("unmapped", q, 32'h00000000);
    end
    wr_reg(EIFX_OFS_IRQ_EN, 32'h00000000, 4'hF);
    // immediate sources: port change, list wrap, host fault
    for (int b = 2; b < 5; b++) begin
      pulse(b);
      cyc_n(1);
      chk("irq masked", irq, 1'b0);
      rd_reg(EIFX_OFS_STATUS, q);
      chk("status", q[5:0], 6'h01 << b);
      wr_reg(EIFX_OFS_IRQ_EN, 32'h00000001 << b, 4'hF);
      cyc_n(1);
      chk("irq enabled", irq, 1'b1);
      wr_reg(EIFX_OFS_STATUS, 32'h00000001 << b, 4'hF);
      cyc_n(1);
      chk("irq cleared", irq, 1'b0);
      pulse(b);
      #1;
      chk("irq early", irq, 1'b0);
      cyc_n(1);
      chk("irq prompt", irq, 1'b1);
      wr_reg(EIFX_OFS_STATUS, 32'h00000001 << b, 4'hF);
      cyc_n(1);
      chk("irq cleared", irq, 1'b0);
      wr_reg(EIFX_OFS_IRQ_EN, 32'h00000000, 4'hF);
    end
    // threshold sources wait for the microframe boundary
    foreach (thr[k]) begin
      wr_reg(EIFX_OFS_IRQ_EN, 32'h00000001 << thr[k], 4'hF);
      wr_reg(EIFX_OFS_FRAME_IDX, 32'h00000000, 4'hF);
      pulse(thr[k]);
      cyc_n(3 * M);
      chk("irq halted", irq, 1'b0);
      wr_reg(EIFX_OFS_COMMAND, 32'h00000001, 4'hF);
      cyc_n(2);
      chk("running", halted, 1'b0);
      chk("irq before boundary", irq, 1'b0);
      wait_tick(n);
      chk("irq at boundary", irq, 1'b1);
      cyc_n(1);
      wait_tick(n);
      chk("tick spacing", n + 1, M);
      wr_reg(EIFX_OFS_FRAME_IDX, 32'h00003FF0, 4'hF);
      rd_reg(EIFX_OFS_FRAME_IDX, q);
      chk("index while running", q, 32'h00000002);
      wr_reg(EIFX_OFS_COMMAND, 32'h00000000, 4'hF);
      wait_halt();
      wr_reg(EIFX_OFS_STATUS, 32'h0000003F, 4'hF);
      cyc_n(1);
      chk("irq cleared", irq, 1'b0);
    end
    // every list length code, preloaded one short of the rollover
    for (int c = 0; c < 4; c++) begin
      top = (c == 1) ? 14'h0FFF : (c == 2) ? 14'h07FF : 14'h1FFF;
      wr_reg(EIFX_OFS_COMMAND, c << 2, 4'hF);
      wr_reg(EIFX_OFS_FRAME_IDX, {18'h00000, top}, 4'hF);
      cyc_n(2);
      chk("entry code", ent, ent_exp(c[1:0], top));
      wr_reg(EIFX_OFS_IRQ_EN, 32'h00000008, 4'hF);
      wr_reg(EIFX_OFS_COMMAND, (c << 2) | 1, 4'hF);
      wait_tick(n);
      idx = top + 14'h0001;
      chk("sof wrap", sof, idx[13:3]);
      chk("entry wrap", ent, ent_exp(c[1:0], idx));
      cyc_n(1);
      chk("irq wrap", irq, 1'b1);
      wr_reg(EIFX_OFS_COMMAND, c << 2, 4'hF);
      wait_halt();
      rd_reg(EIFX_OFS_STATUS, q);
      chk("status wrap", q, 32'h00001008);
      wr_reg(EIFX_OFS_STATUS, 32'h0000003F, 4'hF);
      wr_reg(EIFX_OFS_IRQ_EN, 32'h00000000, 4'hF);
    end
    wrap_up();
  end
endmodule
